// >>> design/sample_fifo_pkg.sv
// Package for the sample FIFO control block: register map, field layout,
// reset values and FIFO geometry.
// Assumes an 8-bit register port with byte addresses as printed.
package sample_fifo_pkg;

    // ==========================================================
    // FIFO geometry
    localparam int unsigned IDX_W       = 8;
    localparam int unsigned CNT_W       = 9;
    localparam int unsigned LOST_W      = 7;
    localparam int unsigned SAMPLE_W    = 24;
    localparam logic [8:0]  FIFO_DEPTH  = 9'h100;
    localparam logic [6:0]  LOST_MAX    = 7'h7F;
    localparam logic [1:0]  LAST_BYTE   = 2'h2;

    // ==========================================================
    // Register addresses
    localparam logic [7:0] ADDR_STATUS1 = 8'h00;
    localparam logic [7:0] ADDR_WR_IDX  = 8'h03;
    localparam logic [7:0] ADDR_RD_IDX  = 8'h04;
    localparam logic [7:0] ADDR_COUNT1  = 8'h05;
    localparam logic [7:0] ADDR_COUNT2  = 8'h06;
    localparam logic [7:0] ADDR_DATA    = 8'h07;
    localparam logic [7:0] ADDR_WM      = 8'h08;
    localparam logic [7:0] ADDR_CTRL    = 8'h09;
    localparam logic [7:0] ADDR_INT_EN  = 8'h58;

    // ==========================================================
    // Field positions
    localparam int unsigned BIT_A_FULL     = 7;
    localparam int unsigned BIT_FRAME_RDY  = 6;
    localparam int unsigned BIT_DATA_RDY   = 5;
    localparam int unsigned BIT_MARK       = 5;
    localparam int unsigned BIT_FLUSH      = 4;
    localparam int unsigned BIT_STAT_CLR   = 3;
    localparam int unsigned BIT_AF_TYPE    = 2;
    localparam int unsigned BIT_ROLLOVER   = 1;
    localparam int unsigned BIT_AF_INT_EN  = 7;

    // ==========================================================
    // Reset values and fixed words
    localparam logic [7:0]  WM_RESET       = 8'h7F;
    localparam logic        STAT_CLR_RESET = 1'b1;
    localparam logic [7:0]  EMPTY_READ     = 8'hFF;
    localparam logic [23:0] MARKER_WORD    = 24'hFF_FFFE;

endpackage

// >>> design/sample_store.sv
// Sample storage array for the circular FIFO.
// Assumes one write port and a combinational read at the read index.
`timescale 1ns/10ps
module sample_store #(
    parameter int unsigned WIDTH  = 24,
    parameter int unsigned ADDR_W = 8
) (
    // Clock
    input  wire logic              sys_clk_i,
    // Write side
    input  wire logic              wr_en_i,
    input  wire logic [ADDR_W-1:0] wr_addr_i,
    input  wire logic [WIDTH-1:0]  wr_data_i,
    // Read side
    input  wire logic [ADDR_W-1:0] rd_addr_i,
    output logic      [WIDTH-1:0]  rd_data_o
);

    logic [WIDTH-1:0] mem_reg [2**ADDR_W];

    always_ff @(posedge sys_clk_i) begin
        if (wr_en_i) begin
            mem_reg[wr_addr_i] <= wr_data_i;
        end
    end

    assign rd_data_o = mem_reg[rd_addr_i];

endmodule

// >>> design/sample_fifo_control.sv
// Control logic of the 256-entry circular sample FIFO: watermark, marker,
// flush, status clearing, stop or roll-over on full, register port.
// Assumes the serial interface turns bus cycles into one-cycle read and
// write strobes on the same clock, and the sequencer pushes on that clock.
`timescale 1ns/10ps
module sample_fifo_control (
    // Clock and reset
    input  wire logic                                 sys_clk_i,
    input  wire logic                                 rst_b_i,
    // Sample push from the sequencer
    input  wire logic                                 push_valid_i,
    input  wire logic [sample_fifo_pkg::SAMPLE_W-1:0] push_data_i,
    input  wire logic                                 frame_done_i,
    // Register port
    input  wire logic [7:0]                           reg_addr_i,
    input  wire logic                                 reg_wr_i,
    input  wire logic [7:0]                           reg_wdata_i,
    input  wire logic                                 reg_rd_i,
    output logic      [7:0]                           reg_rdata_o,
    // Interrupt pin, active low
    output logic                                      interrupt_out_n
);
    import sample_fifo_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        logic [IDX_W-1:0]  write_index;
        logic [IDX_W-1:0]  read_index;
        logic [CNT_W-1:0]  fill_count;
        logic [LOST_W-1:0] lost_sample_count;
        logic [1:0]        byte_sel;
        logic [7:0]        watermark;
        logic              marker_pend;
        logic              port_read_clears_status;
        logic              af_policy;
        logic              rollover_on_full;
        logic              af_int_en;
        logic              a_full;
        logic              frame_rdy;
        logic              data_rdy;
        logic              armed;
        logic [7:0]        rdata;
    } state_t;

    state_t s_reg;
    state_t s_next;

    logic [SAMPLE_W-1:0] rd_word;
    logic [SAMPLE_W-1:0] item;
    logic                wr_en;
    logic                data_rd;
    logic                stat_rd;
    logic                rd_done;
    logic                item_push;
    logic                full_now;
    logic                accept;
    logic                overwrite;
    logic                drop;
    logic                clr;
    logic                af_set;
    logic [CNT_W-1:0]    thr;
    logic [CNT_W-1:0]    cnt_after;

    sample_store #(
        .WIDTH  (SAMPLE_W),
        .ADDR_W (IDX_W)
    ) u_store (
        .sys_clk_i (sys_clk_i),
        .wr_en_i   (wr_en),
        .wr_addr_i (s_reg.write_index),
        .wr_data_i (item),
        .rd_addr_i (s_reg.read_index),
        .rd_data_o (rd_word)
    );

    // ==========================================================
    // Event decode
    always_comb begin
        data_rd   = reg_rd_i && (reg_addr_i == ADDR_DATA);
        stat_rd   = reg_rd_i && (reg_addr_i == ADDR_STATUS1);
        rd_done   = data_rd && (s_reg.fill_count != '0) && (s_reg.byte_sel == LAST_BYTE);
        item_push = push_valid_i || s_reg.marker_pend;
        item      = push_valid_i ? push_data_i : MARKER_WORD;
        full_now  = (s_reg.fill_count == FIFO_DEPTH) && !rd_done;
        accept    = item_push && !full_now;
        overwrite = item_push && full_now && s_reg.rollover_on_full;
        drop      = item_push && full_now && !s_reg.rollover_on_full;
        wr_en     = accept || overwrite;
        cnt_after = s_reg.fill_count + CNT_W'(accept) - CNT_W'(rd_done);
        thr       = FIFO_DEPTH - {1'b0, s_reg.watermark};
        // Policy one needs a read since the last assertion
        af_set    = (wr_en || rd_done) && (cnt_after >= thr)
                    && (!s_reg.af_policy || s_reg.armed);
        clr       = stat_rd || (data_rd && s_reg.port_read_clears_status);
    end

    // ==========================================================
    // Next state
    always_comb begin
        s_next = s_reg;

        // Indices wrap naturally at eight bits
        s_next.write_index = s_reg.write_index + IDX_W'(wr_en);
        s_next.read_index  = s_reg.read_index + IDX_W'(rd_done || overwrite);
        s_next.fill_count  = cnt_after;
        if (overwrite) begin
            s_next.byte_sel = '0;
        end else if (data_rd && s_reg.fill_count != '0) begin
            s_next.byte_sel = (s_reg.byte_sel == LAST_BYTE) ? 2'h0 : s_reg.byte_sel + 2'h1;
        end

        if (rd_done) begin
            s_next.lost_sample_count = LOST_W'(overwrite || drop);
        end else if ((overwrite || drop) && s_reg.lost_sample_count != LOST_MAX) begin
            s_next.lost_sample_count = s_reg.lost_sample_count + 7'h1;
        end

        if (!push_valid_i) begin
            s_next.marker_pend = 1'b0;
        end

        // Set wins over clear for every status flag
        s_next.a_full    = af_set || (s_reg.a_full && !clr);
        s_next.frame_rdy = frame_done_i || (s_reg.frame_rdy && !clr);
        s_next.data_rdy  = wr_en || (s_reg.data_rdy && !clr);
        if (rd_done) begin
            s_next.armed = 1'b1;
        end else if (af_set) begin
            s_next.armed = 1'b0;
        end

        if (reg_rd_i) begin
            unique case (reg_addr_i)
                ADDR_STATUS1: s_next.rdata = {s_reg.a_full, s_reg.frame_rdy, s_reg.data_rdy, 5'h00};
                ADDR_WR_IDX:  s_next.rdata = s_reg.write_index;
                ADDR_RD_IDX:  s_next.rdata = s_reg.read_index;
                ADDR_COUNT1:  s_next.rdata = {s_reg.fill_count[CNT_W-1], s_reg.lost_sample_count};
                ADDR_COUNT2:  s_next.rdata = s_reg.fill_count[7:0];
                ADDR_DATA: begin
                    if (s_reg.fill_count == '0) begin
                        s_next.rdata = EMPTY_READ;
                    end else begin
                        unique case (s_reg.byte_sel)
                            2'h0:    s_next.rdata = rd_word[23:16];
                            2'h1:    s_next.rdata = rd_word[15:8];
                            default: s_next.rdata = rd_word[7:0];
                        endcase
                    end
                end
                ADDR_WM:      s_next.rdata = s_reg.watermark;
                ADDR_CTRL:    s_next.rdata = {2'h0, s_reg.marker_pend, 1'b0, s_reg.port_read_clears_status,
                                              s_reg.af_policy, s_reg.rollover_on_full, 1'b0};
                ADDR_INT_EN:  s_next.rdata = {s_reg.af_int_en, 7'h00};
                default:      s_next.rdata = 8'h00;
            endcase
        end

        if (reg_wr_i) begin
            unique case (reg_addr_i)
                ADDR_WM: s_next.watermark = reg_wdata_i;
                ADDR_CTRL: begin
                    s_next.marker_pend             = s_next.marker_pend || reg_wdata_i[BIT_MARK];
                    s_next.port_read_clears_status = reg_wdata_i[BIT_STAT_CLR];
                    s_next.af_policy               = reg_wdata_i[BIT_AF_TYPE];
                    s_next.rollover_on_full        = reg_wdata_i[BIT_ROLLOVER];
                end
                ADDR_INT_EN: s_next.af_int_en = reg_wdata_i[BIT_AF_INT_EN];
                ADDR_RD_IDX: begin
                    // Retry support: count follows the new read position
                    s_next.read_index = reg_wdata_i;
                    s_next.byte_sel   = '0;
                    s_next.fill_count = {1'b0, s_next.write_index - reg_wdata_i};
                end
                default: ;
            endcase
            // Flush overrides the index, count, lost, byte-phase and arming updates this cycle
            if (reg_addr_i == ADDR_CTRL && reg_wdata_i[BIT_FLUSH]) begin
                s_next.write_index       = '0;
                s_next.read_index        = '0;
                s_next.fill_count        = '0;
                s_next.lost_sample_count = '0;
                s_next.byte_sel          = '0;
                s_next.armed             = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            s_reg                         <= '0;
            s_reg.watermark               <= WM_RESET;
            s_reg.port_read_clears_status <= STAT_CLR_RESET;
            s_reg.armed                   <= 1'b1;
            s_reg.rdata                   <= EMPTY_READ;
        end else begin
            s_reg <= s_next;
        end
    end

    assign reg_rdata_o     = s_reg.rdata;
    assign interrupt_out_n = !(s_reg.a_full && s_reg.af_int_en);

    // ==========================================================
    // Checks
    irq_pin_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (af_set && s_reg.af_int_en && !(reg_wr_i && reg_addr_i == ADDR_INT_EN)) |=> !interrupt_out_n)
        else $error("interrupt pin not driven by enabled almost-full");

    af_level_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (wr_en && cnt_after == thr && !s_reg.af_policy) |=> s_reg.a_full)
        else $error("almost-full not set at watermark");

    marker_push_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (s_reg.marker_pend && !push_valid_i && !full_now) |-> wr_en ##1 !s_reg.marker_pend)
        else $error("marker not pushed or bit not cleared");

    flush_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (reg_wr_i && reg_addr_i == ADDR_CTRL && reg_wdata_i[BIT_FLUSH]) |=>
        (s_reg.write_index == '0 && s_reg.read_index == '0 && s_reg.fill_count == '0
         && s_reg.lost_sample_count == '0))
        else $error("flush left state behind");

    data_keep_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (data_rd && !s_reg.port_read_clears_status && s_reg.a_full) |=> s_reg.a_full)
        else $error("data read cleared almost-full with stat-clear off");

    data_clear_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (data_rd && s_reg.port_read_clears_status && !frame_done_i) |=> !s_reg.frame_rdy)
        else $error("data read did not clear frame-ready");

    stop_full_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (drop && !reg_wr_i) |=> $stable(s_reg.write_index) && $stable(s_reg.read_index))
        else $error("indices moved on drop");

    roll_adv_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (overwrite && !reg_wr_i) |=> (s_reg.read_index == $past(s_reg.read_index) + 8'h01)
        && (s_reg.fill_count == FIFO_DEPTH))
        else $error("roll-over did not advance read index");

    lost_sat_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (s_reg.lost_sample_count == LOST_MAX && !rd_done && !reg_wr_i) |=> s_reg.lost_sample_count == LOST_MAX)
        else $error("lost counter wrapped");

    three_byte_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (rd_done && !reg_wr_i) |=> s_reg.byte_sel == 2'h0 && s_reg.lost_sample_count <= 7'h01)
        else $error("sample read did not restart byte phase");

    count_max_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        s_reg.fill_count <= FIFO_DEPTH)
        else $error("fill count above depth");

endmodule

// >>> bench/host_reader.sv
// Host processor model: reads and writes the register port one byte at a time.
// Assumes one-cycle strobes on sys_clk_i and registered read data one cycle later.
`timescale 1ns/10ps
module host_reader (
    // Clock
    input  wire logic       sys_clk_i,
    // Register port
    output logic      [7:0] reg_addr_o,
    output logic            reg_wr_o,
    output logic      [7:0] reg_wdata_o,
    output logic            reg_rd_o,
    input  wire logic [7:0] reg_rdata_i
);
    import sample_fifo_pkg::*;

    initial begin
        reg_addr_o  = 8'h00;
        reg_wr_o    = 1'b0;
        reg_wdata_o = 8'h00;
        reg_rd_o    = 1'b0;
    end

    // ==========================================================
    // Byte cycles; released write data shows its inverse
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        #1;
        reg_addr_o  = a;
        reg_wdata_o = d;
        reg_wr_o    = 1'b1;
        @(posedge sys_clk_i);
        #1;
        reg_wr_o    = 1'b0;
        reg_wdata_o = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        #1;
        reg_addr_o = a;
        reg_rd_o   = 1'b1;
        @(posedge sys_clk_i);
        #1;
        reg_rd_o   = 1'b0;
        d          = reg_rdata_i;
    endtask

    // ==========================================================
    // Whole sample from the data port, high byte first
    task automatic rd_sample(output logic [23:0] w);
        logic [7:0] b;
        for (int i = 2; i >= 0; i--) begin
            rd(ADDR_DATA, b);
            w[i*8 +: 8] = b;
        end
    endtask
endmodule

// >>> bench/sample_fifo_control_bench.sv
// Self-checking bench for the sample FIFO control block.
// Assumes host_reader drives the register port; a queue model predicts results.
`timescale 1ns/10ps
module sample_fifo_control_bench;
    import sample_fifo_pkg::*;

    logic        sys_clk_i = 1'b0;
    logic        rst_b_i;
    logic        push_valid_i;
    logic [23:0] push_data_i;
    logic        frame_done_i;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, b;
    logic        reg_wr, reg_rd, interrupt_out_n;
    int          n_errors = 0, check_count = 0, seed = 83301;
    int          q[$];
    int          hist[256];
    int          cnt = 0, wi = 0, ri = 0, lost = 0;
    bit          ro = 0;

    always #5 sys_clk_i = ~sys_clk_i;

    sample_fifo_control i_sample_fifo_control (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .push_valid_i(push_valid_i),
        .push_data_i(push_data_i), .frame_done_i(frame_done_i), .reg_addr_i(reg_addr),
        .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata), .interrupt_out_n(interrupt_out_n));

    host_reader i_host_reader (
        .sys_clk_i(sys_clk_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr),
        .reg_wdata_o(reg_wdata), .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata));

    // ==========================================================
    // Model and checks
    task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic void push_m(input int w);
        if (cnt == 256) begin
            if (lost < 127) lost++;
            if (ro) begin
                void'(q.pop_front());
                q.push_back(w);
                hist[wi] = w;
                wi = (wi + 1) % 256;
                ri = (ri + 1) % 256;
            end
        end else begin
            q.push_back(w);
            hist[wi] = w;
            cnt++;
            wi = (wi + 1) % 256;
        end
    endfunction

    task automatic set_ctrl(input logic [7:0] d);
        i_host_reader.wr(ADDR_CTRL, d);
        ro = d[BIT_ROLLOVER];
        if (d[BIT_FLUSH]) begin
            q.delete();
            cnt = 0; wi = 0; ri = 0; lost = 0;
        end
        if (d[BIT_MARK]) push_m(int'(MARKER_WORD));
    endtask

    // Retry: move the read index back and rebuild the queue from history
    task automatic set_rd(input logic [7:0] x);
        i_host_reader.wr(ADDR_RD_IDX, x);
        ri = int'(x);
        cnt = (wi - ri + 256) % 256;
        q.delete();
        for (int k = 0; k < cnt; k++) begin
            q.push_back(hist[(ri + k) % 256]);
        end
    endtask

    task automatic push_n(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk_i);
            #1;
            push_data_i  = 24'($random(seed));
            push_valid_i = 1'b1;
            push_m(int'(push_data_i));
        end
        @(posedge sys_clk_i);
        #1;
        push_valid_i = 1'b0;
    endtask

    task automatic frame_pulse();
        @(posedge sys_clk_i);
        #1;
        frame_done_i = 1'b1;
        @(posedge sys_clk_i);
        #1;
        frame_done_i = 1'b0;
    endtask

    task automatic read_chk();
        logic [23:0] w;
        i_host_reader.rd_sample(w);
        chk("sample", w, 24'(q.pop_front()));
        ri = (ri + 1) % 256;
        cnt--;
        lost = 0;
    endtask

    task automatic chk_regs();
        i_host_reader.rd(ADDR_WR_IDX, b);
        chk("write_index", b, 24'(wi));
        i_host_reader.rd(ADDR_RD_IDX, b);
        chk("read_index", b, 24'(ri));
        i_host_reader.rd(ADDR_COUNT1, b);
        chk("count_hi_lost", b, 24'((cnt / 256) * 128 + lost));
        i_host_reader.rd(ADDR_COUNT2, b);
        chk("count_lo", b, 24'(cnt % 256));
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #200_000;
        n_errors++;
        summarize();
    end

    // ==========================================================
    // Tests
    initial begin
        rst_b_i = 1'b0; push_valid_i = 1'b0; push_data_i = 24'h00_0000; frame_done_i = 1'b0;
        repeat (4) @(posedge sys_clk_i);
        #1;
        rst_b_i = 1'b1;
        i_host_reader.rd(ADDR_WM, b);
        chk("wm_reset", b, 24'h00_007F);
        i_host_reader.rd(ADDR_CTRL, b);
        chk("ctrl_reset", b, 24'h00_0008);
        i_host_reader.rd(ADDR_DATA, b);
        chk("empty_read", b, 24'(EMPTY_READ));
        i_host_reader.rd(8'h20, b);
        chk("unmapped", b, 24'h00_0000);
        chk_regs();
        $display("test reset done");

        i_host_reader.wr(ADDR_WM, 8'hFC);
        i_host_reader.wr(ADDR_INT_EN, 8'h80);
        set_ctrl(8'h10);
        push_n(3);
        chk("int_n", interrupt_out_n, 24'h1);
        push_n(1);
        chk("int_n", interrupt_out_n, 24'h0);
        frame_pulse();
        read_chk();
        chk("int_n", interrupt_out_n, 24'h0);
        i_host_reader.rd(ADDR_STATUS1, b);
        chk("status", b, 24'h00_00E0);
        chk("int_n", interrupt_out_n, 24'h1);
        push_n(1);
        chk("int_n", interrupt_out_n, 24'h0);
        i_host_reader.rd(ADDR_STATUS1, b);
        push_n(1);
        chk("int_n", interrupt_out_n, 24'h0);
        $display("test policy zero done");

        set_ctrl(8'h14);
        push_n(4);
        i_host_reader.rd(ADDR_STATUS1, b);
        push_n(1);
        chk("int_n", interrupt_out_n, 24'h1);
        read_chk();
        chk("int_n", interrupt_out_n, 24'h1);
        push_n(1);
        chk("int_n", interrupt_out_n, 24'h0);
        i_host_reader.wr(ADDR_INT_EN, 8'h00);
        chk("int_n_masked", interrupt_out_n, 24'h1);
        i_host_reader.rd(ADDR_INT_EN, b);
        chk("int_en", b, 24'h00_0000);
        i_host_reader.wr(ADDR_INT_EN, 8'h80);
        chk("int_n_unmasked", interrupt_out_n, 24'h0);
        i_host_reader.wr(ADDR_WR_IDX, 8'h55);
        chk_regs();
        set_rd(8'h00);
        chk_regs();
        read_chk();
        chk_regs();
        $display("test policy one done");

        set_ctrl(8'h18);
        push_n(4);
        frame_pulse();
        read_chk();
        chk("int_n", interrupt_out_n, 24'h1);
        i_host_reader.rd(ADDR_STATUS1, b);
        chk("status", b, 24'h00_0000);
        set_ctrl(8'h28);
        i_host_reader.rd(ADDR_CTRL, b);
        chk("mark_clear", b, 24'h00_0008);
        chk_regs();
        repeat (4) read_chk();
        $display("test marker done");

        push_n(386);
        chk_regs();
        read_chk();
        chk_regs();
        push_n(2);
        chk_regs();
        set_ctrl(8'h0A);
        push_n(3);
        chk_regs();
        read_chk();
        set_ctrl(8'h1A);
        chk_regs();
        $display("test full and flush done");
        summarize();
    end
endmodule
